/* hdl/bmf_ctrl.v */
`timescale 1ns/10ps
`include "bmf_regs.vh"
// Operation
// - turn gate on at every switch oscillator cycle start unless inhibited
// - gate off on current trip or maximum on-time, whichever first
// - maximum on-time is 66 percent of switching period
// - inhibit turn-on on regulation reached, over-temperature or undervoltage lockout
// - above 140 C kill switch and startup; restart below 100 C
// - ignore current comparator during blanking that tracks switch period
// - at startup threshold stop startup source and begin switching
// - in on state choose startup or normal from sensed supply level
// - on/off and data logic work only with drain above 50 V
// - low clamp means data-off, high clamp means data-on
// - count pulses per burst, flag data threshold, feed data and tracking
// - tracking zero below 28, linear from 28 up to 112
// - tracking saturates at counter state 112 and above
// - regulation 20 V to 40 percent duty, falling to 17.5 V at 100
// - data-on after burst above 56, kept until a burst below threshold
// - off state keeps startup source and switch disabled
// - regulation reached stops switching until next burst period start
module bmf_ctrl (
    // apb
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // analog comparator and oscillator inputs (asynchronous)
    input wire switch_osc,
    input wire burst_osc,
    input wire current_trip,
    input wire on_switch,
    input wire drain_above_50v,
    input wire vaux_at_start,
    input wire undervoltage_lockout,
    input wire temp_above_140,
    input wire temp_below_100,
    input wire vaux_at_reg,
    // power stage controls
    output reg gate_drive,
    output reg startup_src_en,
    output reg on_off_data_pin_high,
    output reg [7:0] track_level,
    output reg [15:0] reg_target_mv
);

////////////////////////////////////////////////////////////////////////////////
// state codes
localparam ST_OFF = 2'd0;
localparam ST_STARTUP = 2'd1;
localparam ST_OPER = 2'd2;
// reset words and percentages at their working widths
localparam [31:0] CTRL_RST = `BMF_CTRL_RST_VAL;
localparam [31:0] TIM_RST = `BMF_TIM_RST_VAL;
localparam [7:0] MAX_ON_PCT = `BMF_MAX_ON_PCT;
localparam [6:0] KNEE_PCT = `BMF_DUTY_KNEE_PCT;

// tracking value from counter state
function [7:0] track_of;
    input [7:0] n;
    begin
        if (n < `BMF_TRACK_START)
            track_of = 8'h00;
        else if (n >= `BMF_TRACK_END)
            track_of = `BMF_TRACK_END - `BMF_TRACK_START;
        else
            track_of = n - `BMF_TRACK_START;
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// two-flop synchronisers for all analog inputs
reg [9:0] sync1_reg;
reg [9:0] sync2_reg;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        sync1_reg <= 10'h000;
        sync2_reg <= 10'h000;
    end else begin
        sync1_reg <= {switch_osc, burst_osc, current_trip, on_switch, drain_above_50v,
            vaux_at_start, undervoltage_lockout, temp_above_140, temp_below_100,
            vaux_at_reg};
        sync2_reg <= sync1_reg;
    end
end
wire s_sw = sync2_reg[9];
wire s_burst = sync2_reg[8];
wire s_trip = sync2_reg[7];
wire s_on = sync2_reg[6];
wire s_drain = sync2_reg[5];
wire s_start = sync2_reg[4];
wire s_undervoltage_lockout = sync2_reg[3];
wire s_hot = sync2_reg[2];
wire s_cool = sync2_reg[1];
wire s_reg = sync2_reg[0];

////////////////////////////////////////////////////////////////////////////////
// apb registers
reg enable_reg;
reg [15:0] leb_const_reg;
wire wr_en = psel & penable & pwrite;
assign pready = 1'b1;
assign pslverr = 1'b0;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        enable_reg <= CTRL_RST[`BMF_CTRL_ENABLE];
        leb_const_reg <= TIM_RST[`BMF_TIM_CONST_LSB +: 16];
    end else if (wr_en) begin
        if (paddr == `BMF_CTRL_OFF)
            enable_reg <= pwdata[`BMF_CTRL_ENABLE];
        else if (paddr == `BMF_TIMING_OFF)
            leb_const_reg <= pwdata[31:16];
    end
end

////////////////////////////////////////////////////////////////////////////////
// edge detection of oscillators
reg sw_d_reg;
reg burst_d_reg;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        sw_d_reg <= 1'b0;
        burst_d_reg <= 1'b0;
    end else begin
        sw_d_reg <= s_sw;
        burst_d_reg <= s_burst;
    end
end
wire cycle_start = s_sw & ~sw_d_reg;
wire burst_start = s_burst & ~burst_d_reg;

////////////////////////////////////////////////////////////////////////////////
// period measurement of switch oscillator
reg [15:0] phase_reg;
reg [15:0] period_reg;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        phase_reg <= 16'h0000;
        period_reg <= 16'hFFFF;
    end else if (cycle_start) begin
        phase_reg <= 16'h0001;
        period_reg <= phase_reg;
    end else if (phase_reg != 16'hFFFF) begin
        phase_reg <= phase_reg + 16'h0001;
    end
end
wire [23:0] max_on_prod = period_reg * MAX_ON_PCT;
wire [23:0] max_on_q = max_on_prod / 24'd100;
wire [15:0] max_on = max_on_q[15:0];
wire [15:0] leb_len = leb_const_reg + (period_reg >> `BMF_LEB_DIV_SHIFT);

////////////////////////////////////////////////////////////////////////////////
// supply state machine and temperature hysteresis
reg [1:0] state_reg;
reg hot_reg;
wire active = enable_reg & s_on & s_drain;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        state_reg <= ST_OFF;
        hot_reg <= 1'b0;
    end else begin
        if (s_hot)
            hot_reg <= 1'b1;
        else if (s_cool)
            hot_reg <= 1'b0;
        if (!active)
            state_reg <= ST_OFF;
        else if (state_reg == ST_OFF)
            state_reg <= ST_STARTUP;
        else if (s_undervoltage_lockout)
            state_reg <= ST_STARTUP;
        else if (state_reg == ST_STARTUP && s_start)
            state_reg <= ST_OPER;
    end
end
always @(posedge pclk or negedge presetn) begin
    if (!presetn)
        startup_src_en <= 1'b0;
    else
        startup_src_en <= (state_reg == ST_STARTUP) & ~hot_reg & ~s_start;
end

////////////////////////////////////////////////////////////////////////////////
// regulation stop until next burst
reg reg_stop_reg;
always @(posedge pclk or negedge presetn) begin
    if (!presetn)
        reg_stop_reg <= 1'b0;
    else if (s_reg)
        reg_stop_reg <= 1'b1;
    else if (burst_start)
        reg_stop_reg <= 1'b0;
end

////////////////////////////////////////////////////////////////////////////////
// gate driver
wire inhibit = reg_stop_reg | s_reg | hot_reg | s_undervoltage_lockout | (state_reg != ST_OPER);
reg [15:0] on_cnt_reg;
wire pulse_start = cycle_start & ~inhibit;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        gate_drive <= 1'b0;
        on_cnt_reg <= 16'h0000;
    end else if (pulse_start) begin
        gate_drive <= 1'b1;
        on_cnt_reg <= 16'h0001;
    end else if (gate_drive) begin
        on_cnt_reg <= on_cnt_reg + 16'h0001;
        if (inhibit || on_cnt_reg >= max_on || (s_trip && on_cnt_reg >= leb_len))
            gate_drive <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// pulse counter, data clamp and tracking
reg [7:0] pulse_cnt_reg;
reg [7:0] last_cnt_reg;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pulse_cnt_reg <= 8'h00;
        last_cnt_reg <= 8'h00;
        on_off_data_pin_high <= 1'b0;
        track_level <= 8'h00;
    end else if (!active) begin
        pulse_cnt_reg <= 8'h00;
        on_off_data_pin_high <= 1'b0;
    end else if (burst_start) begin
        last_cnt_reg <= pulse_cnt_reg;
        // a burst of exactly the threshold neither sets nor clears data-on
        if (pulse_cnt_reg > `BMF_DATA_THRESH)
            on_off_data_pin_high <= 1'b1;
        else if (pulse_cnt_reg < `BMF_DATA_THRESH)
            on_off_data_pin_high <= 1'b0;
        track_level <= track_of(pulse_cnt_reg);
        pulse_cnt_reg <= pulse_start ? 8'h01 : 8'h00;
    end else if (pulse_start && pulse_cnt_reg != 8'hFF) begin
        pulse_cnt_reg <= pulse_cnt_reg + 8'h01;
    end
end

////////////////////////////////////////////////////////////////////////////////
// burst duty measurement and regulation target
reg [15:0] bphase_reg;
reg [15:0] bhigh_reg;
reg [15:0] bper_reg;
reg [15:0] bduty_reg;
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        bphase_reg <= 16'h0000;
        bhigh_reg <= 16'h0000;
        bper_reg <= 16'h0001;
        bduty_reg <= 16'h0000;
    end else if (burst_start) begin
        bphase_reg <= 16'h0001;
        bper_reg <= (bphase_reg == 16'h0000) ? 16'h0001 : bphase_reg;
        bduty_reg <= bhigh_reg;
        bhigh_reg <= 16'h0000;
    end else begin
        if (bphase_reg != 16'hFFFF)
            bphase_reg <= bphase_reg + 16'h0001;
        if (~reg_stop_reg && bhigh_reg != 16'hFFFF)
            bhigh_reg <= bhigh_reg + 16'h0001;
    end
end
wire [31:0] duty_prod = bduty_reg * 16'd100;
wire [31:0] duty_q = duty_prod / {16'h0000, bper_reg};
wire [6:0] duty_pct = (duty_q > 32'd100) ? 7'd100 : duty_q[6:0];
wire [15:0] drop_span = `BMF_REG_HIGH_MV - `BMF_REG_LOW_MV;
wire [31:0] drop_prod = drop_span * (duty_pct - KNEE_PCT);
wire [31:0] drop_q = drop_prod / 32'd60;
wire [15:0] drop = drop_q[15:0];
always @(posedge pclk or negedge presetn) begin
    if (!presetn)
        reg_target_mv <= `BMF_REG_HIGH_MV;
    else if (duty_pct <= `BMF_DUTY_KNEE_PCT)
        reg_target_mv <= `BMF_REG_HIGH_MV;
    else
        reg_target_mv <= `BMF_REG_HIGH_MV - drop;
end

////////////////////////////////////////////////////////////////////////////////
// read mux
reg [31:0] rd_word;
always @* begin
    rd_word = 32'h0000_0000;
    if (paddr == `BMF_CTRL_OFF)
        rd_word = {31'h0, enable_reg};
    else if (paddr == `BMF_STAT_OFF)
        rd_word = {24'h0, hot_reg, reg_stop_reg, on_off_data_pin_high, startup_src_en,
            gate_drive, 1'b0, state_reg};
    else if (paddr == `BMF_CNT_OFF)
        rd_word = {16'h0, last_cnt_reg, pulse_cnt_reg};
    else if (paddr == `BMF_TRACK_OFF)
        rd_word = {8'h0, reg_target_mv, track_level};
    else if (paddr == `BMF_TIMING_OFF)
        rd_word = {leb_const_reg, period_reg};
end

// read data captured in the setup phase, held through the access phase
always @(posedge pclk or negedge presetn) begin
    if (!presetn)
        prdata <= 32'h0000_0000;
    else if (psel && !penable)
        prdata <= rd_word;
end

endmodule

/* hdl/bmf_regs.vh */
`ifndef BMF_REGS_VH
`define BMF_REGS_VH
// register byte offsets
`define BMF_CTRL_OFF 12'h000
`define BMF_STAT_OFF 12'h004
`define BMF_CNT_OFF 12'h008
`define BMF_TRACK_OFF 12'h00C
`define BMF_TIMING_OFF 12'h010
// control fields
`define BMF_CTRL_ENABLE 0
`define BMF_CTRL_RST_VAL 32'h0000_0001
// timing register fields: switching period and blanking constant, in clocks
`define BMF_TIM_CONST_LSB 16
`define BMF_TIM_RST_VAL 32'h0014_0000
// on-time limit percentage of the switching period
`define BMF_MAX_ON_PCT 66
// pulse counter thresholds
`define BMF_DATA_THRESH 8'd56
`define BMF_TRACK_START 8'd28
`define BMF_TRACK_END 8'd112
// burst duty knee and regulation targets in millivolts
`define BMF_DUTY_KNEE_PCT 40
`define BMF_REG_HIGH_MV 16'd20000
`define BMF_REG_LOW_MV 16'd17500
// blanking tracking shift: blanking = const + period / 16 (period shifted right by 4)
`define BMF_LEB_DIV_SHIFT 4
`endif

/* tb/bmf_chk.sv */
`timescale 1ns/10ps
module bmf_chk (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // comparator and oscillator inputs
    input wire switch_osc,
    input wire on_switch,
    input wire drain_above_50v,
    input wire undervoltage_lockout,
    input wire temp_above_140,
    input wire vaux_at_reg,
    // power stage controls
    input wire gate_drive,
    input wire startup_src_en,
    input wire [7:0] track_level,
    input wire [15:0] reg_target_mv
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    ////////////////////
    // inhibit conditions must reach the outputs within the sync latency
    hot_kill_a: assert property (temp_above_140 [*6] |-> !gate_drive && !startup_src_en)
        else $error("gate or startup on while hot");
    off_kill_a: assert property ((!on_switch) [*6] |-> !gate_drive && !startup_src_en)
        else $error("gate or startup on in off state");
    drain_kill_a: assert property ((!drain_above_50v) [*6] |-> !gate_drive && !startup_src_en)
        else $error("gate or startup on with drain low");
    undervoltage_lockout_gate_a: assert property (undervoltage_lockout [*6] |-> !gate_drive)
        else $error("gate on during lockout");
    reg_stop_a: assert property (vaux_at_reg [*6] |-> !gate_drive)
        else $error("gate on after regulation reached");
    // turn-on only shortly after a switch cycle start, never while starting up
    gate_start_a: assert property ($rose(gate_drive) |-> switch_osc && !$past(switch_osc, 8))
        else $error("gate rose away from cycle start");
    gate_excl_a: assert property (!(gate_drive && startup_src_en))
        else $error("gate and startup source both on");
    // tracking and regulation target stay in their bands
    track_sat_a: assert property (track_level <= 8'd84)
        else $error("tracking above saturation");
    target_band_a: assert property (reg_target_mv >= 16'd17500 && reg_target_mv <= 16'd20000)
        else $error("regulation target out of band");
endmodule
bind bmf_ctrl bmf_chk u_bmf_chk (.pclk, .presetn, .switch_osc, .on_switch, .drain_above_50v,
    .undervoltage_lockout, .temp_above_140, .vaux_at_reg, .gate_drive, .startup_src_en,
    .track_level, .reg_target_mv);

/* tb/bmf_stage.sv */
`timescale 1ns/10ps
module bmf_stage #(parameter int SW = 100, parameter int BU = 7000) (
    // clock and switch
    input wire pclk,
    input wire gate_drive,
    input wire [7:0] trip_after,
    // oscillators and current comparator
    output logic switch_osc = 1'b0,
    output logic burst_osc = 1'b0,
    output logic current_trip = 1'b0
);
    int t = 0;
    int on = 0;
    ////////////////////
    // free oscillators, switch edges half a cycle away from burst edges
    always @(posedge pclk) begin
        t <= t + 1;
        switch_osc <= ((t + SW / 2) % SW) < SW / 2;
        burst_osc <= (t % BU) < BU / 2;
    end
    // primary current ramps while the switch conducts
    always @(posedge pclk) begin
        on <= gate_drive ? on + 1 : 0;
        current_trip <= gate_drive && on >= trip_after;
    end
endmodule

/* tb/tb_bmf_ctrl.sv */
`timescale 1ns/10ps
module tb_bmf_ctrl;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, g_q = 1'b0, b_q = 1'b0;
    logic vaux_at_start = 1'b0, temp_below_100 = 1'b0;
    logic pready, pslverr, switch_osc, burst_osc, current_trip, gate_drive;
    logic startup_src_en, on_off_data_pin_high;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, q;
    logic [7:0] track_level, trip_after = 8'hFF;
    logic [15:0] reg_target_mv;
    logic [4:0] inh = 5'h08; // lockout, hot, regulation, off, drain low
    logic [7:0] trip_tab [3] = '{8'h02, 8'h28, 8'hFF};
    int lo [3] = '{26, 41, 63};
    int hi [3] = '{31, 47, 69};
    int num_errors = 0, total_checks = 0, rises = 0, n, k, i;
    bmf_ctrl u_bmf_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .switch_osc, .burst_osc, .current_trip, .on_switch(!inh[3]),
        .drain_above_50v(!inh[4]), .vaux_at_start, .undervoltage_lockout(inh[0]),
        .temp_above_140(inh[1]), .temp_below_100, .vaux_at_reg(inh[2]), .gate_drive,
        .startup_src_en, .on_off_data_pin_high, .track_level, .reg_target_mv);
    bmf_stage u_bmf_stage (.pclk, .gate_drive, .trip_after, .switch_osc, .burst_osc,
        .current_trip);
    always #5 pclk = ~pclk;
    // gate rise counter and burst start history
    always @(posedge pclk) begin
        g_q <= gate_drive;
        b_q <= burst_osc;
        if (gate_drive === 1'b1 && g_q === 1'b0)
            rises <= rises + 1;
    end
    ////////////////////
    task chk(input bit ok, input string m);
        total_checks++;
        if (!ok) begin
            num_errors++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task summarize;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // one apb transfer, read data left in q
    task apb(input bit w, input [11:0] a, input [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 50);
        q = prdata;
        chk(pslverr === 1'b0, "slave error");
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (i >= 50) begin
            chk(0, "apb timeout");
            summarize;
        end
    endtask
    task wait_rise;
        // a regulation stop may last up to a whole burst period
        for (i = 0; i < 8000 && !(gate_drive === 1'b1 && g_q === 1'b0); i++)
            @(posedge pclk);
        if (i >= 8000) begin
            chk(0, "no gate pulse");
            summarize;
        end
    endtask
    // high time of the next gate pulse in cycles
    task on_time(output int c);
        wait_rise;
        c = 0;
        while (gate_drive === 1'b1 && c < 500) begin
            @(posedge pclk);
            c++;
        end
    endtask
    task burst_edge;
        @(posedge pclk);
        for (i = 0; i < 9000 && !(burst_osc === 1'b1 && b_q === 1'b0); i++)
            @(posedge pclk);
        if (i >= 9000) begin
            chk(0, "no burst edge");
            summarize;
        end
    endtask
    ////////////////////
    initial begin
        repeat (20) @(posedge pclk);
        chk(reg_target_mv === 16'd20000 && gate_drive === 1'b0, "reset values");
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1, 12'h020, 32'hFFFF_FFFF);
        apb(0, 12'h020, 0);
        chk(q === 32'h0000_0000, "unmapped read");
        apb(0, 12'h000, 0);
        chk(q === 32'h0000_0001 && startup_src_en === 1'b0, "off state");
        inh <= 5'h00;
        repeat (10) @(posedge pclk);
        chk(startup_src_en === 1'b1 && gate_drive === 1'b0, "startup");
        vaux_at_start <= 1'b1;
        repeat (10) @(posedge pclk);
        apb(0, 12'h004, 0);
        chk(q[1:0] === 2'd2 && startup_src_en === 1'b0, "operating");
        $display("test startup done");
        for (k = 0; k < 3; k++) begin
            trip_after <= trip_tab[k];
            on_time(n);
            on_time(n);
            chk(n >= lo[k] && n <= hi[k], "on time");
        end
        apb(0, 12'h010, 0);
        chk(q[31:16] === 16'h0014 && q[15:0] >= 99 && q[15:0] <= 101, "timing");
        $display("test on time done");
        trip_after <= 8'h28;
        burst_edge;
        burst_edge;
        repeat (20) @(posedge pclk);
        chk(on_off_data_pin_high === 1'b1 && track_level === 8'd42, "data on");
        chk(reg_target_mv <= 16'd17600, "full duty target");
        apb(0, 12'h008, 0);
        chk(q[15:8] === 8'd70, "burst count register");
        apb(0, 12'h00C, 0);
        chk(q[7:0] === 8'd42 && q[23:8] <= 16'd17600, "tracking register");
        k = rises;
        for (i = 0; i < 3000 && rises - k < 20; i++)
            @(posedge pclk);
        if (i >= 3000) begin
            chk(0, "pulse timeout");
            summarize;
        end
        // regulation level seen briefly: the stop must still last to the burst end
        inh[2] <= 1'b1;
        repeat (200) @(posedge pclk);
        inh[2] <= 1'b0;
        burst_edge;
        chk(rises - k === 20, "regulation stop");
        repeat (20) @(posedge pclk);
        chk(on_off_data_pin_high === 1'b0 && track_level === 8'd0, "data off");
        chk(reg_target_mv === 16'd20000, "low duty target");
        $display("test burst done");
        for (k = 0; k < 5; k++) begin
            inh[k] <= 1'b1;
            vaux_at_start <= (k != 0); // lockout sits below the start level
            repeat (200) @(posedge pclk);
            n = rises;
            repeat (300) @(posedge pclk);
            chk(rises === n && startup_src_en === (k == 0), "inhibit");
            inh[k] <= 1'b0;
            vaux_at_start <= 1'b1;
            repeat (300) @(posedge pclk);
            if (k == 1) begin
                chk(rises === n && startup_src_en === 1'b0, "cooling");
                temp_below_100 <= 1'b1;
                repeat (5) @(posedge pclk);
                temp_below_100 <= 1'b0;
            end
            wait_rise;
        end
        $display("test inhibit done");
        // clearing the enable bit must act like the off state
        apb(1, 12'h000, 32'h0000_0000);
        repeat (10) @(posedge pclk);
        n = rises;
        repeat (300) @(posedge pclk);
        apb(0, 12'h004, 0);
        chk(rises === n && q[1:0] === 2'd0 && startup_src_en === 1'b0, "disabled");
        chk(on_off_data_pin_high === 1'b0 && gate_drive === 1'b0, "disabled outputs");
        $display("test enable done");
        summarize;
    end
endmodule
